/* core/relay_diag_pkg.sv */
// constants shared by the relay switch serial control and diagnosis logic
package relay_diag_pkg;

    localparam int NUM_CHANNELS = 8;
    localparam int WORD_BITS = 16;
    localparam int MODE_BITS = 2;

    // channel mode field codes
    localparam logic [1:0] MODE_STANDBY = 2'h0;
    localparam logic [1:0] MODE_INPUT = 2'h1;
    localparam logic [1:0] MODE_ON = 2'h2;
    localparam logic [1:0] MODE_OFF = 2'h3;

    // reset values
    localparam logic [15:0] INPUT_REG_RESET = 16'hFFFF;
    localparam logic XFER_ERR_RESET = 1'b1;

    // frame length acceptance
    localparam int FRAME_MIN_CLOCKS = 16;
    localparam int FRAME_MODULO = 8;
    localparam logic [4:0] CNT_FIRST = 5'h01;
    localparam logic [4:0] CNT_WRAP_AT = 5'h18;
    localparam logic [4:0] CNT_MIN_OK = 5'h10;

    // timing: figures in their own unit, counts derived from the clock rate
    localparam int CLK_MHZ = 100;
    localparam int OVERLOAD_DELAY_US = 3;
    localparam int OPEN_LOAD_DELAY_US = 30;
    localparam int OVERLOAD_DELAY_CYCLES = OVERLOAD_DELAY_US * CLK_MHZ;
    localparam int OPEN_LOAD_DELAY_CYCLES = OPEN_LOAD_DELAY_US * CLK_MHZ;
    localparam int TIMER_BITS = 12;

endpackage : relay_diag_pkg

/* core/relay_switch_spi_diag.sv */
// serial control and latched diagnosis for an eight channel low-side switch
`timescale 1ns/10ps

module relay_switch_spi_diag #(
    parameter int CHANNELS = relay_diag_pkg::NUM_CHANNELS,
    parameter int OVERLOAD_CYCLES = relay_diag_pkg::OVERLOAD_DELAY_CYCLES,
    parameter int OPEN_LOAD_CYCLES = relay_diag_pkg::OPEN_LOAD_DELAY_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_o,
    input wire logic [CHANNELS-1:0] in_pin_i,
    input wire logic [CHANNELS-1:0] overload_i,
    input wire logic [CHANNELS-1:0] overtemp_i,
    input wire logic [CHANNELS-1:0] open_load_i,
    output logic [CHANNELS-1:0] gate_on_o,
    output logic [CHANNELS-1:0] diag_current_o,
    output logic sleep_o
);

    localparam int W = 2 * CHANNELS;
    localparam int TB = relay_diag_pkg::TIMER_BITS;
    localparam logic [TB-1:0] OVL_LAST = TB'(OVERLOAD_CYCLES - 1);
    localparam logic [TB-1:0] OL_LAST = TB'(OPEN_LOAD_CYCLES - 1);

    // frame clock counter: wraps by eight once past the minimum, keeping modulo and floor
    function automatic logic [4:0] count_step(input logic [4:0] cnt);
        logic [4:0] nxt;
        nxt = cnt + 5'h01;
        if (nxt == relay_diag_pkg::CNT_WRAP_AT)
        begin
            nxt = relay_diag_pkg::CNT_MIN_OK;
        end
        return nxt;
    endfunction : count_step

    function automatic logic [1:0] mode_of(input logic [W-1:0] word, input int ch);
        return word[2*ch +: 2];
    endfunction : mode_of

    // ---------------- reset release ----------------
    logic rst_meta_reg;
    logic rst_sync_reg;

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ---------------- serial clock domain ----------------
    // frame flags are held cleared while the chip is deselected, even if sclk keeps toggling
    logic link_arst_n;
    assign link_arst_n = rst_sync_reg & ~cs_n_i;

    logic [W-1:0] snap_reg;
    logic xfer_err_snap_reg;
    logic started_reg;
    logic fell_reg;
    logic frame_tog_reg;
    logic link_so_reg;
    logic [W-1:0] shift_reg;
    logic [4:0] clk_cnt_reg;

    always_ff @(posedge sclk_i or negedge link_arst_n)
    begin
        if (!link_arst_n)
        begin
            started_reg <= 1'b0;
        end
        else
        begin
            started_reg <= 1'b1;
        end
    end

    // first rising edge shows the snapshot msb, later ones the shifted word
    always_ff @(posedge sclk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            link_so_reg <= 1'b0;
        end
        else if (!cs_n_i)
        begin
            link_so_reg <= started_reg ? shift_reg[W-1] : snap_reg[W-1];
        end
    end

    always_ff @(negedge sclk_i or negedge link_arst_n)
    begin
        if (!link_arst_n)
        begin
            fell_reg <= 1'b0;
        end
        else
        begin
            fell_reg <= 1'b1;
        end
    end

    // shift word and count survive deselect so the system side can read them
    always_ff @(negedge sclk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            shift_reg <= '0;
            clk_cnt_reg <= '0;
            frame_tog_reg <= 1'b0;
        end
        else if (!cs_n_i)
        begin
            // clocks while deselected must not toggle the frame marker
            if (fell_reg)
            begin
                shift_reg <= {shift_reg[W-2:0], si_i};
                clk_cnt_reg <= count_step(clk_cnt_reg);
            end
            else
            begin
                shift_reg <= {snap_reg[W-2:0], si_i};
                clk_cnt_reg <= relay_diag_pkg::CNT_FIRST;
                frame_tog_reg <= ~frame_tog_reg;
            end
        end
    end

    // ---------------- pin synchronisers ----------------
    logic [2:0] ctl_meta_reg;
    logic [2:0] ctl_sync_reg;
    logic tog_meta_reg;
    logic tog_sync_reg;
    logic tog_seen_reg;
    logic link_so_meta_reg;
    logic link_so_sync_reg;
    logic [3*CHANNELS-1:0] pin_meta_reg;
    logic [3*CHANNELS-1:0] pin_sync_reg;
    logic cs_prev_reg;

    wire logic cs_n_s = ctl_sync_reg[0];
    wire logic si_s = ctl_sync_reg[1];
    wire logic started_s = ctl_sync_reg[2];

    always_ff @(posedge ref_clk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            ctl_meta_reg <= 3'h1;
            ctl_sync_reg <= 3'h1;
            tog_meta_reg <= 1'b0;
            tog_sync_reg <= 1'b0;
            link_so_meta_reg <= 1'b0;
            link_so_sync_reg <= 1'b0;
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
            cs_prev_reg <= 1'b1;
        end
        else
        begin
            ctl_meta_reg <= {started_reg, si_i, cs_n_i};
            ctl_sync_reg <= ctl_meta_reg;
            tog_meta_reg <= frame_tog_reg;
            tog_sync_reg <= tog_meta_reg;
            link_so_meta_reg <= link_so_reg;
            link_so_sync_reg <= link_so_meta_reg;
            pin_meta_reg <= {open_load_i, overtemp_i, overload_i};
            pin_sync_reg <= pin_meta_reg;
            cs_prev_reg <= cs_n_s;
        end
    end

    wire logic [CHANNELS-1:0] ovl_s = pin_sync_reg[0 +: CHANNELS];
    wire logic [CHANNELS-1:0] otp_s = pin_sync_reg[CHANNELS +: CHANNELS];
    wire logic [CHANNELS-1:0] ol_s = pin_sync_reg[2*CHANNELS +: CHANNELS];
    wire logic cs_fall = cs_prev_reg & ~cs_n_s;
    wire logic cs_rise = ~cs_prev_reg & cs_n_s;

    logic [CHANNELS-1:0] in_meta_reg;
    logic [CHANNELS-1:0] in_sync_reg;

    always_ff @(posedge ref_clk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            in_meta_reg <= '0;
            in_sync_reg <= '0;
        end
        else
        begin
            in_meta_reg <= in_pin_i;
            in_sync_reg <= in_meta_reg;
        end
    end

    // ---------------- frame acceptance ----------------
    logic [W-1:0] input_reg;
    logic xfer_err_reg;
    logic [CHANNELS-1:0] fault_reg;
    logic [CHANNELS-1:0] open_load_reg;
    logic [W-1:0] diag_word;

    always_comb
    begin
        for (int ch = 0; ch < CHANNELS; ch++)
        begin
            diag_word[2*ch] = fault_reg[ch];
            diag_word[2*ch+1] = open_load_reg[ch];
        end
    end

    // shift word and count are quiet once deselected, so a direct read is safe
    wire logic new_frame = tog_sync_reg != tog_seen_reg;
    wire logic len_ok = (clk_cnt_reg[2:0] == 3'h0) && (clk_cnt_reg >= relay_diag_pkg::CNT_MIN_OK);

    always_ff @(posedge ref_clk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            input_reg <= relay_diag_pkg::INPUT_REG_RESET;
            xfer_err_reg <= relay_diag_pkg::XFER_ERR_RESET;
            tog_seen_reg <= 1'b0;
        end
        else if (cs_rise)
        begin
            tog_seen_reg <= tog_sync_reg;
            if (new_frame && len_ok)
            begin
                input_reg <= shift_reg;
                xfer_err_reg <= 1'b0;
            end
            else
            begin
                xfer_err_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            snap_reg <= '0;
            xfer_err_snap_reg <= relay_diag_pkg::XFER_ERR_RESET;
        end
        else if (cs_fall)
        begin
            snap_reg <= diag_word;
            xfer_err_snap_reg <= xfer_err_reg;
        end
    end

    // serial output follows the link after the first rising clock
    always_ff @(posedge ref_clk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            so_o <= 1'b0;
            so_oe_o <= 1'b0;
        end
        else
        begin
            so_oe_o <= ~cs_n_s;
            if (cs_n_s)
            begin
                so_o <= 1'b0;
            end
            else if (!started_s)
            begin
                so_o <= xfer_err_snap_reg | si_s;
            end
            else
            begin
                so_o <= link_so_sync_reg;
            end
        end
    end

    // ---------------- channel control and protection ----------------
    logic [TB-1:0] ovl_timer_reg [CHANNELS];
    logic [TB-1:0] ol_timer_reg [CHANNELS];
    logic [CHANNELS-1:0] want_on;
    logic [CHANNELS-1:0] is_standby;
    logic [CHANNELS-1:0] diag_en;

    always_comb
    begin
        for (int ch = 0; ch < CHANNELS; ch++)
        begin
            unique case (mode_of(input_reg, ch))
                relay_diag_pkg::MODE_STANDBY:
                begin
                    want_on[ch] = 1'b0;
                    diag_en[ch] = 1'b0;
                end
                relay_diag_pkg::MODE_INPUT:
                begin
                    want_on[ch] = in_sync_reg[ch];
                    diag_en[ch] = ~in_sync_reg[ch];
                end
                relay_diag_pkg::MODE_ON:
                begin
                    want_on[ch] = 1'b1;
                    diag_en[ch] = 1'b0;
                end
                relay_diag_pkg::MODE_OFF:
                begin
                    want_on[ch] = 1'b0;
                    diag_en[ch] = 1'b1;
                end
            endcase
            is_standby[ch] = mode_of(input_reg, ch) == relay_diag_pkg::MODE_STANDBY;
        end
    end

    // a set arriving while standby is selected wins over the clear
    always_ff @(posedge ref_clk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            fault_reg <= '0;
            for (int ch = 0; ch < CHANNELS; ch++)
            begin
                ovl_timer_reg[ch] <= '0;
            end
        end
        else
        begin
            for (int ch = 0; ch < CHANNELS; ch++)
            begin
                if (gate_on_o[ch] && ovl_s[ch])
                begin
                    ovl_timer_reg[ch] <= (ovl_timer_reg[ch] == OVL_LAST) ?
                        ovl_timer_reg[ch] : ovl_timer_reg[ch] + 1'b1;
                end
                else
                begin
                    ovl_timer_reg[ch] <= '0;
                end
                if (otp_s[ch] || (gate_on_o[ch] && ovl_s[ch] && ovl_timer_reg[ch] == OVL_LAST))
                begin
                    fault_reg[ch] <= 1'b1;
                end
                else if (is_standby[ch])
                begin
                    fault_reg[ch] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            open_load_reg <= '0;
            for (int ch = 0; ch < CHANNELS; ch++)
            begin
                ol_timer_reg[ch] <= '0;
            end
        end
        else
        begin
            for (int ch = 0; ch < CHANNELS; ch++)
            begin
                if (diag_en[ch] && !gate_on_o[ch] && ol_s[ch])
                begin
                    ol_timer_reg[ch] <= (ol_timer_reg[ch] == OL_LAST) ?
                        ol_timer_reg[ch] : ol_timer_reg[ch] + 1'b1;
                end
                else
                begin
                    ol_timer_reg[ch] <= '0;
                end
                if (diag_en[ch] && !gate_on_o[ch] && ol_s[ch] && ol_timer_reg[ch] == OL_LAST)
                begin
                    open_load_reg[ch] <= 1'b1;
                end
                else if (is_standby[ch])
                begin
                    open_load_reg[ch] <= 1'b0;
                end
            end
        end
    end

    // a faulted channel stays off until its flag is cleared through standby
    always_ff @(posedge ref_clk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            gate_on_o <= '0;
            diag_current_o <= '0;
            sleep_o <= 1'b0;
        end
        else
        begin
            for (int ch = 0; ch < CHANNELS; ch++)
            begin
                gate_on_o[ch] <= want_on[ch] && !fault_reg[ch] && !otp_s[ch]
                    && !(ovl_s[ch] && ovl_timer_reg[ch] == OVL_LAST);
                diag_current_o[ch] <= diag_en[ch];
            end
            sleep_o <= &is_standby;
        end
    end

endmodule : relay_switch_spi_diag

/* tb/relay_diag_properties.sv */
// concurrent checks on the relay switch serial and channel ports
`timescale 1ns/10ps

module relay_diag_properties #(
    parameter int CHANNELS = 8,
    parameter int OVERLOAD_CYCLES = 4
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic so_o,
    input wire logic so_oe_o,
    input wire logic [CHANNELS-1:0] overload_i,
    input wire logic [CHANNELS-1:0] overtemp_i,
    input wire logic [CHANNELS-1:0] gate_on_o,
    input wire logic [CHANNELS-1:0] diag_current_o,
    input wire logic sleep_o
);
    int unsigned ovl_cnt;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // only channel 2 is watched: the count must restart when its gate drops
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ovl_cnt <= 0;
        else if (overload_i[2] && gate_on_o[2])
            ovl_cnt <= ovl_cnt + 1;
        else
            ovl_cnt <= 0;
    end

    oe_release_a: assert property (cs_n_i [*5] |-> !so_oe_o)
        else $error("serial output driven while deselected");
    so_idle_a: assert property (!so_oe_o |-> !so_o)
        else $error("serial output not parked while released");
    oe_open_a: assert property ($fell(cs_n_i) |-> ##[1:4] so_oe_o)
        else $error("serial output not driven after select");
    oe_hold_a: assert property ((!cs_n_i) [*6] |-> so_oe_o)
        else $error("serial output dropped inside a frame");
    oe_close_a: assert property ($rose(cs_n_i) |-> ##[1:5] !so_oe_o)
        else $error("serial output still driven after deselect");
    overtemp_off_a: assert property ((overtemp_i != 0 && $stable(overtemp_i)) [*6]
        |-> (gate_on_o & overtemp_i) == '0)
        else $error("hot channel left on");
    ovl_limit_a: assert property (ovl_cnt <= OVERLOAD_CYCLES + 4)
        else $error("overloaded channel not shut off in time");
    diag_off_a: assert property ((gate_on_o & diag_current_o) == '0)
        else $error("diagnosis current on a conducting channel");
    sleep_quiet_a: assert property (sleep_o |-> gate_on_o == '0 && diag_current_o == '0)
        else $error("channel active while asleep");

    frame_c: cover property ($fell(cs_n_i) ##[1:4] so_oe_o);
    ovl_c: cover property (overload_i[2] && gate_on_o[2] ##[1:20] !gate_on_o[2]);
    sleep_c: cover property ($rose(sleep_o));
endmodule : relay_diag_properties

/* tb/spi_master_model.sv */
// serial master standing in for the host controller
`timescale 1ns/10ps

module spi_master_model (
    input wire logic so_i,
    input wire logic so_oe_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic si_o
);
    localparam time HALF = 80ns;

    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end

    // a released output reads as unknown so it can never pass a compare
    function automatic logic line_of();
        return so_oe_i ? so_i : 1'bx;
    endfunction : line_of

    task automatic xfer(input int n, input logic [31:0] tx, output logic first,
        output logic [31:0] rx);
        rx = '0;
        si_o = (n > 0) ? tx[n-1] : 1'b0;
        #HALF;
        cs_n_o = 1'b0;
        #HALF;
        first = line_of();
        for (int i = n - 1; i >= 0; i--)
        begin
            sclk_o = 1'b1;
            #HALF;
            rx[i] = line_of();
            sclk_o = 1'b0;
            #(HALF / 2);
            si_o = (i > 0) ? tx[i-1] : ~si_o;
            #(HALF / 2);
        end
        cs_n_o = 1'b1;
        si_o = ~si_o;
        #(2 * HALF);
    endtask : xfer

    // clock and data wiggle while deselected, only when the bench asks
    task automatic noise(input int n);
        for (int i = 0; i < n; i++)
        begin
            si_o = ~si_o;
            #HALF sclk_o = 1'b1;
            #HALF sclk_o = 1'b0;
        end
    endtask : noise
endmodule : spi_master_model

/* tb/testbench.sv */
// self-checking bench for the relay switch serial control and diagnosis
`timescale 1ns/10ps

`define CHK(what, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("mismatch %s expected %h seen %h", what, exp, got); \
        end \
    end

module testbench;
    localparam int OVL = 4;
    localparam int OL = 8;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sclk, cs_n, si, so, so_oe, sleep, first;
    logic [7:0] in_pin = '0;
    logic [7:0] overload = '0;
    logic [7:0] overtemp = '0;
    logic [7:0] open_load = '0;
    logic [7:0] gate_on, diag_current;
    logic [31:0] rx;
    logic [15:0] words [3] = '{16'h6AAA, 16'hE4E4, 16'h1B1B};
    int mismatches = 0;
    int comparisons = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    relay_switch_spi_diag #(.OVERLOAD_CYCLES(OVL), .OPEN_LOAD_CYCLES(OL)) u_relay_switch_spi_diag (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si),
        .so_o(so), .so_oe_o(so_oe), .in_pin_i(in_pin), .overload_i(overload),
        .overtemp_i(overtemp), .open_load_i(open_load), .gate_on_o(gate_on),
        .diag_current_o(diag_current), .sleep_o(sleep));

    spi_master_model master_model (.so_i(so), .so_oe_i(so_oe), .sclk_o(sclk), .cs_n_o(cs_n),
        .si_o(si));

    // {diag current, gate} for a mode word with nothing latched
    function automatic logic [15:0] expect_pins(input logic [15:0] w, input logic [7:0] pin);
        logic [1:0] m;
        logic [15:0] r;
        r = '0;
        for (int c = 0; c < 8; c++)
        begin
            m = w[2*c +: 2];
            r[c] = m == relay_diag_pkg::MODE_ON || (m == relay_diag_pkg::MODE_INPUT && pin[c]);
            r[8+c] = m == relay_diag_pkg::MODE_OFF || (m == relay_diag_pkg::MODE_INPUT && !pin[c]);
        end
        return r;
    endfunction : expect_pins

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    task automatic frame(input int n, input logic [31:0] tx);
        @(negedge ref_clk_i);
        master_model.xfer(n, tx, first, rx);
        repeat (4) @(negedge ref_clk_i);
    endtask : frame

    task automatic test_end(input string name);
        $display("test %s finished, mismatches %0d", name, mismatches);
    endtask : test_end

    initial
    begin
        #200us;
        mismatches++;
        final_report();
    end

    initial
    begin
        repeat (12) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        repeat (10) @(negedge ref_clk_i);
        `CHK("pins after reset", 16'hFF00, {diag_current, gate_on})
        `CHK("sleep after reset", 1'b0, sleep)
        frame(16, 32'h0000_6AAA);
        `CHK("error bit after reset", 1'b1, first)
        `CHK("diag after reset", 16'h0000, rx[15:0])
        test_end("reset");
        foreach (words[k])
            for (int p = 0; p < 2; p++)
            begin
                in_pin = p ? 8'hFF : 8'h00;
                frame(16, {16'h0000, words[k]});
                `CHK("pins per mode", expect_pins(words[k], in_pin), {diag_current, gate_on})
            end
        `CHK("error bit after good frame", 1'b0, first)
        test_end("modes");
        frame(12, 32'h0000_0000);
        `CHK("pins after short frame", expect_pins(16'h1B1B, in_pin), {diag_current, gate_on})
        frame(24, 32'h00A5_6AAA);
        `CHK("error bit after short frame", 1'b1, first)
        `CHK("diag then passed bits", 24'h00_00A5, rx[23:0])
        `CHK("word from long frame", expect_pins(16'h6AAA, in_pin), {diag_current, gate_on})
        master_model.noise(21);
        frame(16, 32'h0000_2AAB);
        `CHK("error bit after idle noise", 1'b0, first)
        test_end("lengths");
        open_load = 8'h03;
        overload = 8'h04;
        overtemp = 8'h08;
        for (int t = 0; t < 60 && gate_on[3:2] !== 2'b00; t++)
            @(negedge ref_clk_i);
        if (gate_on[3:2] !== 2'b00)
        begin
            mismatches++;
            final_report();
        end
        // open-load qualification plus input synchronisers
        repeat (OL + 12) @(negedge ref_clk_i);
        open_load = 8'h00;
        overload = 8'h00;
        overtemp = 8'h00;
        frame(16, 32'h0000_AAAB);
        `CHK("latched flags", 16'h0052, rx[15:0])
        `CHK("gates held off", 8'hF2, gate_on)
        frame(16, 32'h0000_AA08);
        `CHK("flags kept", 16'h0052, rx[15:0])
        frame(16, 32'h0000_0000);
        `CHK("flags cleared", 16'h0000, rx[15:0])
        `CHK("sleep when all standby", 1'b1, sleep)
        test_end("faults");
        final_report();
    end
endmodule : testbench

bind relay_switch_spi_diag relay_diag_properties #(.CHANNELS(CHANNELS),
    .OVERLOAD_CYCLES(OVERLOAD_CYCLES)) u_relay_diag_properties (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .so_o(so_o), .so_oe_o(so_oe_o),
    .overload_i(overload_i), .overtemp_i(overtemp_i), .gate_on_o(gate_on_o),
    .diag_current_o(diag_current_o), .sleep_o(sleep_o));
